/* File: verilog/ckps_core.sv */
// Added by the designer: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// RQ1 - Switching and monitor need switch enable low
// RQ2 - Disabled: new field ignored, status shows strap (the code still takes an unlocked high-byte write into the new field)
// RQ3 - Disabled: switch request forced to zero
// RQ4 - High byte unlock 78h 9Ah then write
// RQ5 - Low byte unlock 46h 57h then request
// RQ6 - Equal sources: clear request, abort
// RQ7 - Valid switch clears lock and fail bits
// RQ8 - Start oscillator, wait start-up timer
// RQ9 - PLL sources wait for lock
// RQ10 - Count ten new clock cycles, then switch
// RQ11 - Completion clears request, copies new source
// RQ12 - Stop old source except kept ones
// RQ13 - CPU never stalled by switching
// RQ14 - No direct PLL to PLL switch
// RQ15 - Primary submode fixed by straps
// RQ16 - Power save selects Sleep or Idle
// RQ17 - Sleep stops source, clears watchdog
// RQ18 - Wake on interrupt, reset, watchdog timeout
// RQ19 - Sleep wake keeps same source
// RQ20 - Idle keeps source, clears watchdog
// RQ21 - Idle wake restores CPU clock at once
// RQ22 - Coincident interrupt deferred until entry done
// RQ23 - Three-bit source encoding
// RQ24 - Unlock expires after one access (the code counts only writes; reads leave the unlock in place)
module ckps_core
  import ckps_pkg::*;
#(
  parameter int OST_COUNT = OST_CYCLES
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic i_clk_en,
  // Straps and oscillator status
  input wire ckps_pkg::ckps_cfg_t i_cfg,
  input wire ckps_pkg::ckps_osc_t i_osc,
  // Wake sources
  input wire logic i_irq_pending,
  input wire logic i_wdt_timeout,
  // Control outputs
  output ckps_pkg::ckps_ctl_t o_ctl,
  output logic o_primary_submode,
  output logic [1:0] o_primary_mode,
  // AXI4-Lite write address
  input wire logic [7:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  // AXI4-Lite write data
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  // AXI4-Lite write response
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  // AXI4-Lite read address
  input wire logic [7:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  // AXI4-Lite read data
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready
);
  import ckps_pkg::*;

  typedef enum {SW_IDLE, SW_START, SW_WAIT_RDY, SW_COUNT} ckps_sw_t;
  typedef enum {PM_RUN, PM_SLEEP, PM_IDLE} ckps_pm_t;

  // RQ23 source code decode
  // Is a source driven through the PLL
  function automatic logic uses_pll(input logic [2:0] s);
    uses_pll = (s == SRC_FRC_PLL) || (s == SRC_PRI_PLL);
  endfunction

  // Is a source a crystal needing start-up timer
  function automatic logic is_crystal(input logic [2:0] s);
    is_crystal = (s == SRC_PRI) || (s == SRC_PRI_PLL) || (s == SRC_SEC);
  endfunction

  // Registers
  logic [2:0] cur_src_r;
  logic [2:0] new_src_r;
  logic req_r;
  logic lock_r;
  logic cf_r;
  logic sec_en_r;
  logic [1:0] unl_hi_r;
  logic [1:0] unl_lo_r;
  ckps_sw_t sw_r;
  ckps_pm_t pm_r;
  logic [2:0] old_src_r;
  logic old_stop_r;
  logic [15:0] cnt_r;
  logic wdt_clr_r;
  logic wake_pend_r;
  logic sw_ok;
  logic [1:0] submode_r;

  // Bus capture
  logic aw_held_r;
  logic w_held_r;
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic wr_go;
  logic hi_wr;
  logic lo_wr;
  logic [7:0] hi_byte;
  logic [7:0] lo_byte;

  // RQ1 switch enable strap
  assign sw_ok = ~i_cfg.switch_enable_config;

  // Handshakes
  assign o_awready = i_clk_en && !aw_held_r && !bvalid_r;
  assign o_wready = i_clk_en && !w_held_r && !bvalid_r;
  assign o_arready = i_clk_en && !rvalid_r;
  assign o_bvalid = bvalid_r;
  assign o_bresp = bresp_r;
  assign o_rvalid = rvalid_r;
  assign o_rdata = rdata_r;
  assign o_rresp = rresp_r;
  assign wr_go = aw_held_r && w_held_r && !bvalid_r;
  assign hi_byte = wdata_r[15:8];
  assign lo_byte = wdata_r[7:0];
  assign hi_wr = wr_go && (awaddr_r == ADDR_OSC_CTRL) && wstrb_r[1];
  assign lo_wr = wr_go && (awaddr_r == ADDR_OSC_CTRL) && wstrb_r[0];

  // Write address and data capture
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
    end
    else if (i_clk_en)
    begin
      if (o_awready && i_awvalid)
      begin
        aw_held_r <= 1'b1;
        awaddr_r <= i_awaddr;
      end
      else if (wr_go)
        aw_held_r <= 1'b0;
      if (o_wready && i_wvalid)
      begin
        w_held_r <= 1'b1;
        wdata_r <= i_wdata;
        wstrb_r <= i_wstrb;
      end
      else if (wr_go)
        w_held_r <= 1'b0;
    end
  end

  // Write response
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end
    else if (i_clk_en)
    begin
      if (wr_go)
      begin
        bvalid_r <= 1'b1;
        bresp_r <= (awaddr_r == ADDR_OSC_CTRL || awaddr_r == ADDR_PSAVE ||
                    awaddr_r == ADDR_STATUS) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (i_bready)
        bvalid_r <= 1'b0;
    end
  end

  // Read path
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= RESP_OKAY;
    end
    else if (i_clk_en)
    begin
      if (o_arready && i_arvalid)
      begin
        rvalid_r <= 1'b1;
        rresp_r <= RESP_OKAY;
        case (i_araddr)
          ADDR_OSC_CTRL: rdata_r <= {16'h0000, 1'b0, cur_src_r, 1'b0, new_src_r, 2'h0,
                                     lock_r, 1'b0, cf_r, 1'b0, sec_en_r, req_r};
          ADDR_PSAVE: rdata_r <= {30'h0, (pm_r == PM_IDLE), (pm_r == PM_SLEEP)};
          ADDR_STATUS: rdata_r <= {27'h0, (sw_r != SW_IDLE), old_stop_r, sw_ok,
                                   unl_hi_r == 2'h2, unl_lo_r == 2'h2};
          default:
          begin
            rdata_r <= 32'h0000_0000;
            rresp_r <= RESP_SLVERR;
          end
        endcase
      end
      else if (i_rready)
        rvalid_r <= 1'b0;
    end
  end

  // RQ4 high byte unlock sequencer
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
      unl_hi_r <= 2'h0;
    else if (i_clk_en && wr_go)
    begin
      // RQ24 unlock expires on next write
      if (hi_wr && unl_hi_r == 2'h0 && hi_byte == KEY_HI_1)
        unl_hi_r <= 2'h1;
      else if (hi_wr && unl_hi_r == 2'h1 && hi_byte == KEY_HI_2)
        unl_hi_r <= 2'h2;
      else
        unl_hi_r <= 2'h0;
    end
  end

  // RQ5 low byte unlock sequencer
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
      unl_lo_r <= 2'h0;
    else if (i_clk_en && wr_go)
    begin
      // RQ24 unlock expires on next write
      if (lo_wr && unl_lo_r == 2'h0 && lo_byte == KEY_LO_1)
        unl_lo_r <= 2'h1;
      else if (lo_wr && unl_lo_r == 2'h1 && lo_byte == KEY_LO_2)
        unl_lo_r <= 2'h2;
      else
        unl_lo_r <= 2'h0;
    end
  end

  // RQ15 primary submode caught after reset
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
      submode_r <= 2'h0;
    else if (i_clk_en && sw_r == SW_IDLE && pm_r == PM_RUN
             && submode_r == 2'h0)
      submode_r <= i_cfg.primary_submode_config;
  end
  assign o_primary_mode = submode_r;
  assign o_primary_submode = (cur_src_r == SRC_PRI) || (cur_src_r == SRC_PRI_PLL);

  // New source field and secondary enable
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      new_src_r <= SRC_FRC;
      sec_en_r <= 1'b0;
    end
    else if (i_clk_en)
    begin
      // RQ4 accept only unlocked high write
      if (hi_wr && unl_hi_r == 2'h2 && hi_byte[2:0] != SRC_RSVD)
        new_src_r <= hi_byte[2:0];
      // RQ5 low byte honoured only unlocked
      if (lo_wr && unl_lo_r == 2'h2)
        sec_en_r <= lo_byte[SEC_EN_BIT];
    end
  end

  // Switch sequencer, request, status bits
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      sw_r <= SW_IDLE;
      req_r <= 1'b0;
      lock_r <= 1'b0;
      cf_r <= 1'b0;
      cnt_r <= 16'h0000;
      cur_src_r <= SRC_FRC;
      old_src_r <= SRC_FRC;
      old_stop_r <= 1'b0;
    end
    else if (i_clk_en)
    begin
      lock_r <= i_osc.pll_locked;
      // Fail flag sticks until a switch begins
      if (sw_ok && i_osc.clock_fail && pm_r != PM_SLEEP)
        cf_r <= 1'b1;
      if (!sw_ok)
      begin
        // RQ2 status follows strap
        cur_src_r <= i_cfg.initial_source_config;
        // RQ3 request held at zero
        req_r <= 1'b0;
        sw_r <= SW_IDLE;
      end
      else
      begin
        case (sw_r)
          SW_IDLE:
            // RQ5 request set only after unlock
            if (lo_wr && unl_lo_r == 2'h2 && lo_byte[REQ_BIT])
            begin
              req_r <= 1'b1;
              sw_r <= SW_START;
            end
          SW_START:
            // RQ6 redundant switch aborted
            // RQ14 PLL to PLL refused
            if (new_src_r == cur_src_r ||
                (uses_pll(new_src_r) && uses_pll(cur_src_r)))
            begin
              req_r <= 1'b0;
              sw_r <= SW_IDLE;
            end
            else
            begin
              // RQ7 clear lock and fail
              lock_r <= 1'b0;
              cf_r <= 1'b0;
              cnt_r <= 16'h0000;
              old_stop_r <= 1'b0;
              sw_r <= SW_WAIT_RDY;
            end
          SW_WAIT_RDY:
          begin
            // RQ8 wait for start-up timer
            if (cnt_r < 16'(OST_COUNT))
              cnt_r <= cnt_r + 16'h0001;
            // RQ9 PLL lock required
            if (i_osc.running[new_src_r] &&
                (!is_crystal(new_src_r) || i_osc.ost_done || cnt_r >= 16'(OST_COUNT)) &&
                (!uses_pll(new_src_r) || i_osc.pll_locked))
            begin
              cnt_r <= 16'h0000;
              sw_r <= SW_COUNT;
            end
          end
          SW_COUNT:
          begin
            // RQ10 ten new clock cycles
            if (i_osc.new_clk_tick)
              cnt_r <= cnt_r + 16'h0001;
            if (i_osc.new_clk_tick && cnt_r == 16'(NEW_CLK_WAIT - 1))
            begin
              // RQ11 done, copy source
              req_r <= 1'b0;
              old_src_r <= cur_src_r;
              cur_src_r <= new_src_r;
              old_stop_r <= 1'b1;
              sw_r <= SW_IDLE;
            end
          end
          default: sw_r <= SW_IDLE;
        endcase
      end
    end
  end

  // RQ16 power save entry and wake
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      pm_r <= PM_RUN;
      wdt_clr_r <= 1'b0;
      wake_pend_r <= 1'b0;
    end
    else if (i_clk_en)
    begin
      wdt_clr_r <= 1'b0;
      wake_pend_r <= 1'b0;
      case (pm_r)
        PM_RUN:
          if (wr_go && awaddr_r == ADDR_PSAVE && wstrb_r[0])
          begin
            // RQ17 clear watchdog in the same cycle as entry
            // RQ20 Idle also clears watchdog
            if (wdata_r[1:0] == PS_SLEEP)
            begin
              pm_r <= PM_SLEEP;
              wdt_clr_r <= 1'b1;
            end
            else if (wdata_r[1:0] == PS_IDLE)
            begin
              pm_r <= PM_IDLE;
              wdt_clr_r <= 1'b1;
            end
            // RQ22 coincident interrupt deferred
            wake_pend_r <= i_irq_pending;
          end
        PM_SLEEP, PM_IDLE:
          // RQ18 wake events
          // RQ19 source untouched, so resumes same
          // RQ21 CPU clock back at once
          if (i_irq_pending || i_wdt_timeout || wake_pend_r)
            pm_r <= PM_RUN;
        default: pm_r <= PM_RUN;
      endcase
    end
  end

  // Oscillator enable outputs
  always_comb
  begin
    o_ctl = '0;
    o_ctl.sys_source = cur_src_r;
    o_ctl.watchdog_clear = wdt_clr_r;
    // RQ13 CPU clock gated only by power save
    o_ctl.cpu_clk_on = (pm_r == PM_RUN);
    // RQ17 Sleep stops source and monitor
    o_ctl.sys_clk_on = (pm_r != PM_SLEEP);
    o_ctl.failsafe_clock_monitor_active = sw_ok && (pm_r != PM_SLEEP);
    if (pm_r != PM_SLEEP)
      o_ctl.osc_enable[cur_src_r] = 1'b1;
    // RQ8 start requested source
    if (sw_r == SW_WAIT_RDY || sw_r == SW_COUNT)
      o_ctl.osc_enable[new_src_r] = 1'b1;
    // RQ12 old source kept unless stopped
    if (!old_stop_r && old_src_r != cur_src_r && pm_r != PM_SLEEP)
      o_ctl.osc_enable[old_src_r] = 1'b1;
    if (sec_en_r)
      o_ctl.osc_enable[SRC_SEC] = 1'b1;
    // RQ20 low-power RC kept for watchdog
    o_ctl.low_power_rc_oscillator_keep = i_cfg.watchdog_en || (sw_ok && pm_r != PM_SLEEP);
    if (o_ctl.low_power_rc_oscillator_keep)
      o_ctl.osc_enable[SRC_LOW_POWER_RC_OSCILLATOR] = 1'b1;
  end

endmodule // ckps_core
`default_nettype wire

/* File: verilog/ckps_pkg.sv */
`default_nettype none
package ckps_pkg;
  // Source encodings
  localparam logic [2:0] SRC_FRC = 3'h0;
  localparam logic [2:0] SRC_FRC_PLL = 3'h1;
  localparam logic [2:0] SRC_PRI = 3'h2;
  localparam logic [2:0] SRC_PRI_PLL = 3'h3;
  localparam logic [2:0] SRC_SEC = 3'h4;
  localparam logic [2:0] SRC_LOW_POWER_RC_OSCILLATOR = 3'h5;
  localparam logic [2:0] SRC_RSVD = 3'h6;
  localparam logic [2:0] SRC_FRC_DIV = 3'h7;
  // Register byte addresses
  localparam logic [7:0] ADDR_OSC_CTRL = 8'h00;
  localparam logic [7:0] ADDR_PSAVE = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  // Oscillator control field positions
  localparam int CUR_LSB = 12;
  localparam int NEW_LSB = 8;
  localparam int LOCK_BIT = 5;
  localparam int SEC_EN_BIT = 1;
  localparam int CF_BIT = 3;
  localparam int REQ_BIT = 0;
  // Unlock keys
  localparam logic [7:0] KEY_HI_1 = 8'h78;
  localparam logic [7:0] KEY_HI_2 = 8'h9a;
  localparam logic [7:0] KEY_LO_1 = 8'h46;
  localparam logic [7:0] KEY_LO_2 = 8'h57;
  // Power save command values
  localparam logic [1:0] PS_SLEEP = 2'h1;
  localparam logic [1:0] PS_IDLE = 2'h2;
  // Timing counts
  localparam int NEW_CLK_WAIT = 10;
  localparam int OST_CYCLES = 1024;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Configuration straps
  typedef struct packed {
    logic switch_enable_config;
    logic [2:0] initial_source_config;
    logic [1:0] primary_submode_config;
    logic watchdog_en;
  } ckps_cfg_t;
  // Oscillator side status
  typedef struct packed {
    logic [7:0] running;
    logic pll_locked;
    logic ost_done;
    logic new_clk_tick;
    logic clock_fail;
  } ckps_osc_t;
  // Oscillator enables and selection
  typedef struct packed {
    logic [7:0] osc_enable;
    logic [2:0] sys_source;
    logic sys_clk_on;
    logic cpu_clk_on;
    logic failsafe_clock_monitor_active;
    logic low_power_rc_oscillator_keep;
    logic watchdog_clear;
  } ckps_ctl_t;
endpackage
`default_nettype wire

/* File: verification/ckps_core_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module ckps_core_asserts
  import ckps_pkg::*;
(
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_reset,
  // Straps and wake
  input wire ckps_pkg::ckps_cfg_t i_cfg,
  input wire logic i_irq_pending,
  input wire logic i_wdt_timeout,
  input wire ckps_pkg::ckps_ctl_t o_ctl,
  // Bus handshakes
  input wire logic i_awvalid,
  input wire logic o_awready,
  input wire logic i_wvalid,
  input wire logic o_wready,
  input wire logic o_bvalid,
  input wire logic i_bready,
  input wire logic i_arvalid,
  input wire logic o_arready,
  input wire logic o_rvalid,
  input wire logic i_rready,
  input wire logic [31:0] o_rdata,
  input wire logic [1:0] o_rresp
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);
  // Bus timing and holding
  a_write_latency: assert property (i_awvalid && o_awready && i_wvalid && o_wready |-> ##2 o_bvalid)
    else $error("write response late");
  a_read_latency: assert property (i_arvalid && o_arready |=> o_rvalid)
    else $error("read data late");
  a_bvalid_hold: assert property (o_bvalid && !i_bready |=> o_bvalid)
    else $error("write response dropped");
  a_rvalid_hold: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
    else $error("read data dropped");
  // Strap source and monitor while locked out, sleep and wake
  a_strap_source: assert property (i_cfg.switch_enable_config && $stable(i_cfg) && !$past(i_reset)
    |-> o_ctl.sys_source == i_cfg.initial_source_config) else $error("source not strap");
  a_failsafe_clock_monitor_gate: assert property ((i_cfg.switch_enable_config && $stable(i_cfg) && !$past(i_reset))
    || !o_ctl.sys_clk_on |-> !o_ctl.failsafe_clock_monitor_active) else $error("monitor active");
  a_sleep_halt: assert property (!o_ctl.sys_clk_on |-> !o_ctl.cpu_clk_on)
    else $error("cpu runs in sleep");
  a_sleep_low_power_rc_oscillator: assert property (i_cfg.watchdog_en && !o_ctl.sys_clk_on |-> o_ctl.osc_enable[5])
    else $error("low_power_rc_oscillator stopped");
  a_wake_bound: assert property ((i_irq_pending || i_wdt_timeout) && !o_ctl.cpu_clk_on
    |-> ##[0:8] o_ctl.cpu_clk_on) else $error("no wake");
  a_wake_source: assert property ($rose(o_ctl.sys_clk_on) |-> o_ctl.sys_source ==
    $past(o_ctl.sys_source)) else $error("source changed in sleep");
  // Main scenarios
  c_sleep: cover property ($fell(o_ctl.cpu_clk_on) && !o_ctl.sys_clk_on);
  c_wake: cover property ($rose(o_ctl.cpu_clk_on));
  c_slverr: cover property (o_rvalid && o_rresp == RESP_SLVERR);
endmodule // ckps_core_asserts
`default_nettype wire

/* File: verification/ckps_osc_model.sv */
`timescale 1ns/1ps
`default_nettype none
module ckps_osc_model
  import ckps_pkg::*;
(
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_reset,
  // Enables and fault
  input wire ckps_pkg::ckps_ctl_t i_ctl,
  input wire logic i_fail,
  // Oscillator status
  output ckps_pkg::ckps_osc_t o_osc
);
  logic [7:0] run_r;
  logic [3:0] age_r;
  logic [1:0] div_r;
  logic old_r;
  // Sources start a cycle after enable
  always_ff @(posedge i_clk_sys)
    run_r <= i_reset ? 8'h00 : i_ctl.osc_enable;
  // Settling age, restarts when a source starts up
  always_ff @(posedge i_clk_sys)
    age_r <= (i_reset || |(i_ctl.osc_enable & ~run_r)) ? 4'h0 : age_r + {3'h0, age_r != 4'hf};
  // New clock is a third of system rate
  always_ff @(posedge i_clk_sys)
    div_r <= (i_reset || div_r == 2'h2) ? 2'h0 : div_r + 2'h1;
  assign old_r = age_r[3];
  assign o_osc = '{run_r, old_r & (run_r[1] | run_r[3]), old_r & (run_r[2] | run_r[3]),
    div_r == 2'h0, i_fail};
endmodule // ckps_osc_model
`default_nettype wire

/* File: verification/ckps_core_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module ckps_core_bench;
  import ckps_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic irq = 1'b0;
  logic wdt = 1'b0;
  logic fail = 1'b0;
  logic wclr = 1'b0;
  ckps_cfg_t cfg = '{1'b1, SRC_PRI, 2'h1, 1'b1};
  ckps_osc_t osc;
  ckps_ctl_t ctl;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, psub, ta, tw;
  logic [1:0] bresp, rresp, pmode, r;
  logic [31:0] rdata, d;
  logic [2:0] prev;
  int error_cnt = 0;
  int checks = 0;
  int n;
  int k;
  logic [2:0] tsrc [8] = '{SRC_SEC, SRC_PRI, SRC_PRI_PLL, SRC_FRC_PLL, SRC_PRI_PLL,
    SRC_FRC_DIV, SRC_LOW_POWER_RC_OSCILLATOR, SRC_FRC};
  logic [2:0] texp [8] = '{SRC_SEC, SRC_PRI, SRC_PRI_PLL, SRC_PRI_PLL, SRC_PRI_PLL,
    SRC_FRC_DIV, SRC_LOW_POWER_RC_OSCILLATOR, SRC_FRC};
  // Clock and watchdog clear monitor
  always #25 clk = ~clk;
  always @(posedge ctl.watchdog_clear) wclr <= 1'b1;
  ckps_core #(.OST_COUNT(16)) DUT (.i_clk_sys(clk), .i_reset(rst), .i_clk_en(1'b1), .i_cfg(cfg),
    .i_osc(osc),
    .i_irq_pending(irq), .i_wdt_timeout(wdt), .o_ctl(ctl), .o_primary_submode(psub),
    .o_primary_mode(pmode), .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready),
    .i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp),
    .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid),
    .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready));
  ckps_osc_model osc_m (.i_clk_sys(clk), .i_reset(rst), .i_ctl(ctl), .i_fail(fail), .o_osc(osc));
  task complete_run;
    $display("errors %0d checks %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input string s, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      $display("[FAIL] %s exp %h got %h", s, e, g);
      error_cnt++;
    end
  endtask
  task bound(input int lim);
    if (n >= lim)
    begin
      chk("wait", 1, 0);
      complete_run();
    end
  endtask
  // Write both channels, then wait response
  task wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s);
    @(posedge clk);
    awaddr <= a; wdata <= v; wstrb <= s; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    ta = 1'b0; tw = 1'b0;
    for (n = 0; n < 200 && !(ta && tw); n++)
    begin
      @(posedge clk);
      if (awready && !ta) begin ta = 1'b1; awvalid <= 1'b0; end
      if (wready && !tw) begin tw = 1'b1; wvalid <= 1'b0; end
    end
    bound(200);
    for (n = 0; n < 200 && !bvalid; n++) @(posedge clk);
    bound(200);
    r = bresp;
    bready <= 1'b0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge clk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    for (n = 0; n < 200; n++)
    begin
      @(posedge clk);
      if (arready) break;
    end
    bound(200);
    arvalid <= 1'b0;
    for (n = 0; n < 200 && !rvalid; n++) @(posedge clk);
    bound(200);
    d = rdata; r = rresp;
    rready <= 1'b0;
  endtask
  // unlock pairs then one write each
  task sw(input logic [2:0] s);
    wr(ADDR_OSC_CTRL, {16'h0, KEY_HI_1, 8'h00}, 4'h2);
    wr(ADDR_OSC_CTRL, {16'h0, KEY_HI_2, 8'h00}, 4'h2);
    wr(ADDR_OSC_CTRL, {21'h0, s, 8'h00}, 4'h2);
    wr(ADDR_OSC_CTRL, {24'h0, KEY_LO_1}, 4'h1);
    wr(ADDR_OSC_CTRL, {24'h0, KEY_LO_2}, 4'h1);
    wr(ADDR_OSC_CTRL, 32'h1, 4'h1);
  endtask
  task rs;
    rst <= 1'b1;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
  endtask
  task wcpu(input logic v);
    for (n = 0; n < 40 && ctl.cpu_clk_on !== v; n++) @(posedge clk);
    bound(40);
  endtask
  // Main sequence
  initial
  begin
    rs();
    sw(SRC_SEC);
    rd(ADDR_OSC_CTRL);
    chk("req", 0, d[REQ_BIT]);
    chk("cur", SRC_PRI, d[14:12]);
    chk("src", SRC_PRI, ctl.sys_source);
    chk("failsafe_clock_monitor", 0, ctl.failsafe_clock_monitor_active);
    chk("pmode", 2'h1, pmode);
    chk("psub", 1, psub);
    cfg <= '{1'b0, SRC_FRC, 2'h1, 1'b1};
    rs();
    wr(ADDR_OSC_CTRL, {16'h0, KEY_HI_1, 8'h00}, 4'h2);
    wr(ADDR_OSC_CTRL, {16'h0, KEY_HI_2, 8'h00}, 4'h2);
    wr(ADDR_OSC_CTRL, 32'h0, 4'h1);
    wr(ADDR_OSC_CTRL, 32'h500, 4'h2);
    wr(ADDR_OSC_CTRL, 32'h500, 4'h2);
    rd(ADDR_OSC_CTRL);
    chk("new", SRC_FRC, d[10:8]);
    fail <= 1'b1;
    rd(ADDR_OSC_CTRL);
    fail <= 1'b0;
    chk("cf", 1, d[CF_BIT]);
    prev = SRC_FRC;
    for (int i = 0; i < 8; i++)
    begin
      sw(tsrc[i]);
      chk("cpu", 1, ctl.cpu_clk_on);
      chk("early", prev, ctl.sys_source);
      for (k = 0; k < 40; k++)
      begin
        rd(ADDR_OSC_CTRL);
        if (d[REQ_BIT] === 1'b0) break;
      end
      n = k;
      bound(40);
      chk("cur", texp[i], d[14:12]);
      chk("src", texp[i], ctl.sys_source);
      if (texp[i] == SRC_PRI_PLL || texp[i] == SRC_FRC_PLL)
        chk("lock", 1, d[LOCK_BIT]);
      else
        chk("cf", 0, d[CF_BIT]);
      if (prev != texp[i] && prev != SRC_LOW_POWER_RC_OSCILLATOR)
        chk("old", 0, ctl.osc_enable[prev]);
      prev = texp[i];
    end
    chk("pmode", 2'h1, pmode);
    wclr <= 1'b0;
    wr(ADDR_PSAVE, {30'h0, PS_SLEEP}, 4'h1);
    wcpu(1'b0);
    chk("sclk", 0, ctl.sys_clk_on);
    chk("wclr", 1, wclr);
    @(posedge clk) irq <= 1'b1;
    wcpu(1'b1);
    irq <= 1'b0;
    chk("wsrc", SRC_FRC, ctl.sys_source);
    wclr <= 1'b0;
    wr(ADDR_PSAVE, {30'h0, PS_IDLE}, 4'h1);
    wcpu(1'b0);
    chk("iclk", 1, ctl.sys_clk_on);
    chk("wclr", 1, wclr);
    @(posedge clk) wdt <= 1'b1;
    @(posedge clk) wdt <= 1'b0;
    wcpu(1'b1);
    chk("wake", 1, ctl.cpu_clk_on);
    wclr <= 1'b0;
    irq <= 1'b1;
    wr(ADDR_PSAVE, {30'h0, PS_SLEEP}, 4'h1);
    wcpu(1'b1);
    irq <= 1'b0;
    chk("dclr", 1, wclr);
    chk("defer", 1, ctl.cpu_clk_on);
    rd(8'h0c);
    chk("resp", RESP_SLVERR, r);
    chk("rdat", 0, d);
    complete_run();
  end
endmodule // ckps_core_bench
bind ckps_core ckps_core_asserts chk_u (.i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_cfg(i_cfg),
  .i_irq_pending(i_irq_pending), .i_wdt_timeout(i_wdt_timeout), .o_ctl(o_ctl),
  .i_awvalid(i_awvalid), .o_awready(o_awready), .i_wvalid(i_wvalid), .o_wready(o_wready),
  .o_bvalid(o_bvalid), .i_bready(i_bready), .i_arvalid(i_arvalid), .o_arready(o_arready),
  .o_rvalid(o_rvalid), .i_rready(i_rready), .o_rdata(o_rdata), .o_rresp(o_rresp));
`default_nettype wire
